// ### verilog/io_port_pkg.sv
// Constants and types for the six-pin I/O port
package io_port_pkg;
   localparam int          NUM_PINS        = 6;      // Port width
   localparam int          NUM_PL_PINS     = 4;      // Pins with pull-low option
   // Register addresses on the core's special-function bus
   localparam logic [3:0]  ADDR_PORT_DATA  = 4'h6;   // Port data, normal page
   localparam logic [3:0]  ADDR_POWER_CTRL = 4'h8;   // Power control, normal page
   localparam logic [3:0]  ADDR_PC_SELECT  = 4'h9;   // Pin-change select
   localparam logic [3:0]  ADDR_PULL_LOW   = 4'hb;   // Pull-low control
   localparam logic [3:0]  ADDR_PULL_HIGH  = 4'hc;   // Pull-high control
   localparam logic [3:0]  ADDR_IRQ_ENABLE = 4'he;   // Interrupt enable
   localparam logic [3:0]  ADDR_IRQ_FLAG   = 4'hf;   // Interrupt flag
   localparam logic [3:0]  ADDR_DIRECTION  = 4'h6;   // Direction, control page
   localparam logic [3:0]  ADDR_OPEN_DRAIN = 4'hc;   // Open-drain, control page
   localparam logic [3:0]  ADDR_GIRQ_TIMER = 4'hf;   // Global irq/timer, control page
   // Field positions
   localparam int          BIT_GIE         = 7;      // Global irq enable
   localparam int          BIT_T0EN        = 0;      // Timer enable
   localparam int          BIT_EIS         = 6;      // Pin 0 external irq
   localparam int          BIT_WDTEN       = 7;      // Watchdog enable
   localparam int          BIT_LVREN       = 3;      // Low-voltage reset enable
   localparam int          BIT_TIF         = 0;      // Timer flag/enable
   localparam int          BIT_PCF         = 1;      // Pin-change flag/enable
   localparam int          BIT_XIF         = 2;      // External irq flag/enable
   localparam int          PL_LSB          = 4;      // Pull-low field low bit
   localparam int          PIN_RESET       = 3;      // Reset / forced open-drain pin
   localparam int          PIN_CLKOUT      = 4;      // Clock output pin
   localparam int          PIN_TCLK        = 2;      // Timer clock input pin
   localparam int          PIN_XIRQ        = 0;      // External irq pin
   // Reset values
   localparam logic [5:0]  RST_DIR         = 6'h3f;  // All inputs
   localparam logic [5:0]  RST_PH          = 6'h3f;  // Pull-high off (active low)
   localparam logic [3:0]  RST_PL          = 4'hf;   // Pull-low off (active low)
   localparam logic [5:0]  RST_PCS         = 6'h3f;  // All pins selected
   localparam logic [5:0]  RST_OD          = 6'h00;  // Push-pull
   localparam logic [2:0]  RST_IE          = 3'h0;   // Interrupts masked
   localparam logic [2:0]  RST_IF          = 3'h0;   // No flags
   localparam logic [7:0]  RST_PWR         = 8'h08;  // LVR on, rest off
   // Operating modes
   typedef enum logic [1:0] {
      MODE_NORMAL  = 2'b00,
      MODE_HALT    = 2'b01,
      MODE_STANDBY = 2'b10,
      MODE_RSVD    = 2'b11
   } op_mode_t;
endpackage

// ### verilog/pin_sync_if.sv
// Interface carrying synchronised pin levels and their change strobes
`timescale 1ns/1ps
interface pin_sync_if;
   logic [5:0] level;   // Synchronised pin levels
   logic [5:0] change;  // One-cycle level-change strobes
   logic [5:0] rise;    // One-cycle rising-edge strobes
   modport source (output level, output change, output rise);
   modport sink   (input  level, input  change, input  rise);
endinterface

// ### verilog/pin_sync.sv
// Two-stage pin synchroniser with change and edge detection
`timescale 1ns/1ps
module pin_sync
   import io_port_pkg::*;
(
   input  wire logic         clk_i,    // Instruction clock
   input  wire logic         rst_i,    // Async reset, active high
   input  wire logic [5:0]   pins_i,   // Raw pad levels
   pin_sync_if.source        sync      // Synchronised result
);
   typedef struct packed {
      logic [5:0] meta;    // First stage, read only by second
      logic [5:0] stage2;  // Second stage
      logic [5:0] prev;    // Previous synchronised level
      logic [2:0] fill;    // Ones shift in as the stages fill
   } sync_state_t;

   sync_state_t st;       // Registered state
   sync_state_t next_st;  // Next state

   // Shift the pads through two flops, then keep one more for edges
   always_comb begin
      next_st        = st;
      next_st.meta   = pins_i;
      next_st.stage2 = st.meta;
      next_st.prev   = st.stage2;
      next_st.fill   = {st.fill[1:0], 1'b1};
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Strobes compare second stage and its delayed copy only
   // Held off until prev holds a real sample, so reset gives no false edge
   assign sync.level  = st.stage2;
   assign sync.change = (st.stage2 ^ st.prev) & {6{st.fill[2]}};
   assign sync.rise   = (st.stage2 & ~st.prev) & {6{st.fill[2]}};
endmodule

// ### verilog/io_port.sv
// Six-pin bidirectional I/O port with pin-change and external interrupt
// Summary of operation
// - Each pin has its own direction bit
// - Per-pin pull-high enable on input pins
// - Pull-low only pins 3..0, bits 7..4
// - Open-drain bit selects open-drain output
// - Pin 3 output is always open-drain
// - Selected input pin change sets pin-change flag
// - Pin-change request needs flag, enable, global
// - External-irq select turns pin 0 into irq
// - External irq removes pin 0 from change
// - Reset option: low pin 3 resets
// - Clock-out option drives clock on pin 4 in normal and standby modes
// - Pin 2 clocks timer when selected
// - Global enable reset 0, instruction set/clear
// - Direction 1 is input; reset input
// - Read returns pin or latch per option
// - Flag holds until software writes zero
// - Flag reads zero while its enable clear
`timescale 1ns/1ps
module io_port
   import io_port_pkg::*;
(
   input  wire logic         REF_CLK_I,       // Instruction clock
   input  wire logic         RST_I,           // Async reset, active high
   input  wire logic [3:0]   ADDR_I,          // Register address
   input  wire logic         CTRL_PAGE_I,     // 1 selects control page
   input  wire logic         WR_I,            // Register write strobe
   input  wire logic         RD_I,            // Register read strobe
   input  wire logic [7:0]   WDATA_I,         // Write data
   output logic [7:0]        RDATA_O,         // Read data, registered
   input  wire logic         ENI_I,           // Enable-interrupts instruction
   input  wire logic         DISABLE_IRQ_INSTR_I,          // Disable-interrupts instruction
   input  wire logic         EDGE_SEL_I,      // External irq edge, 1 rising
   input  wire logic         TIMER_CS_I,      // Timer clock source bit
   input  wire logic         LOW_OSC_TM_I,    // Low-oscillator timer select
   input  wire logic         TIMER_OVF_I,     // Timer overflow pulse
   input  wire logic         OPT_EXT_RST_I,   // Config: pin 3 is reset
   input  wire logic         OPT_CLK_OUT_I,   // Config: clock on pin 4
   input  wire logic         OPT_RD_LATCH_I,  // Config: outputs read latch
   input  wire logic [1:0]   OP_MODE_I,       // Operating mode
   input  wire logic [5:0]   PINS_I,          // Pad input levels
   output logic [5:0]        PINS_O,          // Pad output levels
   output logic [5:0]        PINS_OE_O,       // Pad drive enables
   output logic [5:0]        PULL_HIGH_O,     // Pull-high active
   output logic [3:0]        PULL_LOW_O,      // Pull-low active, pins 3..0
   output logic              PC_IRQ_O,        // Pin-change irq request
   output logic              XIRQ_O,          // External irq request
   output logic              TIMER_IRQ_O,     // Timer irq request
   output logic              TIMER_CLK_O,     // Synchronised timer clock
   output logic              EXT_RST_O,       // Reset request from pin 3
   output logic [7:0]        GIRQ_TIMER_O,    // Global irq/timer register
   output logic [7:0]        POWER_CTRL_O     // Power control register
);
   typedef struct packed {
      logic [5:0] latch;     // Output data latch
      logic [1:0] gp;        // General bits of data register
      logic [5:0] dir;       // Direction, 1 input
      logic [5:0] ph_n;      // Pull-high disable
      logic [3:0] pl_n;      // Pull-low disable
      logic [5:0] od;        // Open-drain select
      logic [5:0] pcs;       // Pin-change select
      logic [2:0] ie;        // Interrupt enables
      logic [2:0] iflag;     // Interrupt flags
      logic [7:0] pwr;       // Power control
      logic       global_irq_enable;       // Global irq enable
      logic       t0en;      // Timer enable
      logic [7:0] rdata;     // Read data
      logic [5:0] pins;      // Pad outputs
      logic [5:0] oe;        // Pad enables
      logic [5:0] ph;        // Pull-high outputs
      logic [3:0] pl;        // Pull-low outputs
      logic [2:0] irq;       // Irq requests
      logic       tclk;      // Timer clock out
      logic       xrst;      // Reset out
      logic       ckdiv;     // Clock-out toggle
   } port_state_t;

   port_state_t st;       // Registered state
   port_state_t next_st;  // Next state
   pin_sync_if  ps ();    // Synchronised pins

   // Pad synchroniser
   pin_sync u_sync (
      .clk_i  (REF_CLK_I),
      .rst_i  (RST_I),
      .pins_i (PINS_I),
      .sync   (ps.source)
   );

   logic [5:0] pc_mask;   // Pins taking part in change detection
   logic       xedge;     // External irq edge seen
   logic       wr_n;      // Normal page write
   logic       wr_c;      // Control page write
   logic [5:0] rd_port;   // Port read value
   logic [5:0] drive;     // Pad output enable
   logic [5:0] odm;       // Effective open-drain
   logic       ckout;     // Clock-out active

   // Decode and next-state logic
   always_comb begin
      next_st = st;
      wr_n    = WR_I & ~CTRL_PAGE_I;
      wr_c    = WR_I & CTRL_PAGE_I;
      // Pin 0 drops out of change when it is the external irq
      pc_mask = st.pcs & st.dir;
      if (st.pwr[BIT_EIS]) begin
         pc_mask[PIN_XIRQ] = 1'b0;
      end
      xedge = st.pwr[BIT_EIS] & (EDGE_SEL_I ? ps.rise[PIN_XIRQ]
              : ps.change[PIN_XIRQ] & ~ps.rise[PIN_XIRQ]);
      // Register writes
      if (wr_n) begin
         case (ADDR_I)
            ADDR_PORT_DATA:  {next_st.gp, next_st.latch} = WDATA_I;
            ADDR_POWER_CTRL: next_st.pwr = WDATA_I;
            ADDR_PC_SELECT:  next_st.pcs = WDATA_I[5:0];
            ADDR_PULL_LOW:   next_st.pl_n = WDATA_I[PL_LSB +: NUM_PL_PINS];
            ADDR_PULL_HIGH:  next_st.ph_n = WDATA_I[5:0];
            ADDR_IRQ_ENABLE: next_st.ie = WDATA_I[2:0];
            ADDR_IRQ_FLAG:   next_st.iflag = st.iflag & WDATA_I[2:0];
            default:         next_st.pwr = st.pwr;
         endcase
      end
      if (wr_c) begin
         case (ADDR_I)
            ADDR_DIRECTION:  next_st.dir = WDATA_I[5:0];
            ADDR_OPEN_DRAIN: next_st.od = WDATA_I[5:0];
            ADDR_GIRQ_TIMER: next_st.t0en = WDATA_I[BIT_T0EN];
            default:         next_st.od = st.od;
         endcase
      end
      // Events set flags; a set wins over a same-cycle clear
      if (|(ps.change & pc_mask)) begin
         next_st.iflag[BIT_PCF] = 1'b1;
      end
      if (xedge) begin
         next_st.iflag[BIT_XIF] = 1'b1;
      end
      if (TIMER_OVF_I) begin
         next_st.iflag[BIT_TIF] = 1'b1;
      end
      // Global enable by instruction only
      if (ENI_I) begin
         next_st.global_irq_enable = 1'b1;
      end else if (DISABLE_IRQ_INSTR_I) begin
         next_st.global_irq_enable = 1'b0;
      end
      // Read path: inputs give pin, outputs per option
      rd_port = ps.level;
      if (OPT_RD_LATCH_I) begin
         rd_port = (st.dir & ps.level) | (~st.dir & st.latch);
      end
      next_st.rdata = 8'h00;
      if (RD_I && !CTRL_PAGE_I) begin
         case (ADDR_I)
            ADDR_PORT_DATA:  next_st.rdata = {st.gp, rd_port};
            ADDR_POWER_CTRL: next_st.rdata = st.pwr;
            ADDR_PC_SELECT:  next_st.rdata = {2'b00, st.pcs};
            ADDR_PULL_LOW:   next_st.rdata = {st.pl_n, 4'hf};
            ADDR_PULL_HIGH:  next_st.rdata = {2'b00, st.ph_n};
            ADDR_IRQ_ENABLE: next_st.rdata = {5'h00, st.ie};
            ADDR_IRQ_FLAG:   next_st.rdata = {5'h00, st.iflag & st.ie};
            default:         next_st.rdata = 8'h00;
         endcase
      end else if (RD_I) begin
         case (ADDR_I)
            ADDR_DIRECTION:  next_st.rdata = {2'b00, st.dir};
            ADDR_OPEN_DRAIN: next_st.rdata = {2'b00, st.od};
            ADDR_GIRQ_TIMER: next_st.rdata = {st.global_irq_enable, 6'h00, st.t0en};
            default:         next_st.rdata = 8'h00;
         endcase
      end
      // Pad drive: direction 0 is output
      ckout = OPT_CLK_OUT_I & ((OP_MODE_I == MODE_NORMAL) | (OP_MODE_I == MODE_STANDBY));
      next_st.ckdiv = ~st.ckdiv;
      odm = st.od;
      odm[PIN_RESET] = 1'b1;
      drive = ~st.dir & ~(odm & st.latch);
      next_st.pins = st.latch;
      if (ckout) begin
         next_st.pins[PIN_CLKOUT] = st.ckdiv;
         drive[PIN_CLKOUT] = 1'b1;
      end
      if (OPT_EXT_RST_I) begin
         drive[PIN_RESET] = 1'b0;
      end
      next_st.oe = drive;
      next_st.ph = st.dir & ~st.ph_n;
      // Clock-out makes pin 4 an output, so its pull-high goes off
      if (ckout) begin
         next_st.ph[PIN_CLKOUT] = 1'b0;
      end
      next_st.pl = st.dir[3:0] & ~st.pl_n;
      // Requests gated by enable and global enable
      next_st.irq = st.iflag & st.ie & {3{st.global_irq_enable}};
      next_st.tclk = TIMER_CS_I & ~LOW_OSC_TM_I & ps.level[PIN_TCLK];
      next_st.xrst = OPT_EXT_RST_I & ~ps.level[PIN_RESET];
   end

   // State register with reset values
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         st       <= '0;
         st.dir   <= RST_DIR;
         st.ph_n  <= RST_PH;
         st.pl_n  <= RST_PL;
         st.pcs   <= RST_PCS;
         st.od    <= RST_OD;
         st.ie    <= RST_IE;
         st.iflag <= RST_IF;
         st.pwr   <= RST_PWR;
         st.global_irq_enable   <= 1'b0;
         st.t0en  <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flops
   assign RDATA_O      = st.rdata;
   assign PINS_O       = st.pins;
   assign PINS_OE_O    = st.oe;
   assign PULL_HIGH_O  = st.ph;
   assign PULL_LOW_O   = st.pl;
   assign TIMER_IRQ_O  = st.irq[BIT_TIF];
   assign PC_IRQ_O     = st.irq[BIT_PCF];
   assign XIRQ_O       = st.irq[BIT_XIF];
   assign TIMER_CLK_O  = st.tclk;
   assign EXT_RST_O    = st.xrst;
   assign GIRQ_TIMER_O = {st.global_irq_enable, 6'h00, st.t0en};
   assign POWER_CTRL_O = st.pwr;
endmodule

// ### verif/pad_model.sv
// Pad model: resolves each pin from the port, the far side and the pulls
`timescale 1ns/1ps
module pad_model (
   input  wire logic       clk_i,     // Instruction clock
   input  wire logic [5:0] out_i,     // Port output levels
   input  wire logic [5:0] oe_i,      // Port drive enables
   input  wire logic [5:0] ph_i,      // Pull-high active
   input  wire logic [3:0] pl_i,      // Pull-low active, pins 3..0
   input  wire logic [5:0] ext_d_i,   // Far-side drive levels
   input  wire logic [5:0] ext_en_i,  // Far-side drive enables
   output logic [5:0]      pad_o      // Resolved pad levels
);
   logic [5:0] last;  // Previous pad level, for floating pins
   // Remember levels so an undriven pin does not hold its value
   always_ff @(posedge clk_i) begin
      last <= pad_o;
   end
   // Port first, then far side, then pulls, else floating
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (oe_i[i]) pad_o[i] = out_i[i];
         else if (ext_en_i[i]) pad_o[i] = ext_d_i[i];
         else if (ph_i[i]) pad_o[i] = 1'b1;
         else if (i < 4 && pl_i[i[1:0]]) pad_o[i] = 1'b0;
         else pad_o[i] = ~last[i];
      end
   end
endmodule

// ### verif/io_port_monitor.sv
// Concurrent checks on the I/O port's top-level ports
`timescale 1ns/1ps
module io_port_monitor (
   input wire logic       REF_CLK_I,
   input wire logic       RST_I,
   input wire logic       RD_I,
   input wire logic [7:0] RDATA_O,
   input wire logic       ENI_I,
   input wire logic       DISABLE_IRQ_INSTR_I,
   input wire logic [7:0] GIRQ_TIMER_O,
   input wire logic [7:0] POWER_CTRL_O,
   input wire logic       PC_IRQ_O,
   input wire logic       XIRQ_O,
   input wire logic       OPT_EXT_RST_I,
   input wire logic [5:0] PINS_I,
   input wire logic       EXT_RST_O,
   input wire logic       TIMER_CS_I,
   input wire logic       LOW_OSC_TM_I,
   input wire logic       TIMER_CLK_O,
   input wire logic [5:0] PINS_O,
   input wire logic [5:0] PINS_OE_O,
   input wire logic [5:0] PULL_HIGH_O
);
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);
   // Pin 3 held low with the reset option on
   sequence s_pin3_low; (OPT_EXT_RST_I && !PINS_I[3])[*4]; endsequence
   // Pin 2 held high with the external timer clock chosen
   sequence s_tclk_high; (TIMER_CS_I && !LOW_OSC_TM_I && PINS_I[2])[*4]; endsequence
   property p_gie_set; ENI_I |=> ##[0:1] GIRQ_TIMER_O[7]; endproperty
   property p_gie_clr; DISABLE_IRQ_INSTR_I && !ENI_I |=> ##[0:1] !GIRQ_TIMER_O[7]; endproperty
   property p_rst_val;
      $fell(RST_I) |-> GIRQ_TIMER_O == 8'h01 && POWER_CTRL_O == 8'h08;
   endproperty
   property p_irq_gate;
      !GIRQ_TIMER_O[7] && !$past(GIRQ_TIMER_O[7]) |-> !PC_IRQ_O && !XIRQ_O;
   endproperty
   property p_ext_rst; s_pin3_low |=> EXT_RST_O; endproperty
   property p_tclk; s_tclk_high |=> TIMER_CLK_O; endproperty
   property p_od_pin3; PINS_OE_O[3] |-> !PINS_O[3]; endproperty
   property p_pull_in; (PULL_HIGH_O & PINS_OE_O) == 6'h00; endproperty
   property p_rd_idle; !$past(RD_I) |-> RDATA_O == 8'h00; endproperty
   a_gie_set: assert property (p_gie_set) else $error("gie not set");
   a_gie_clr: assert property (p_gie_clr) else $error("gie not cleared");
   a_rst_val: assert property (p_rst_val) else $error("bad reset value");
   a_irq_gate: assert property (p_irq_gate) else $error("irq without gie");
   a_ext_rst: assert property (p_ext_rst) else $error("no pin reset");
   a_tclk: assert property (p_tclk) else $error("timer clock missing");
   a_od_pin3: assert property (p_od_pin3) else $error("pin 3 drives high");
   a_pull_in: assert property (p_pull_in) else $error("pull on output");
   a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
endmodule
bind io_port io_port_monitor i_io_port_monitor (.*);

// ### verif/testbench.sv
// Self-checking bench for the six-pin I/O port
`timescale 1ns/1ps
module testbench
   import io_port_pkg::*;
;
   logic clk, rst, page, wr, rd, enable_irq_instr, disable_irq_instr, edge_sel, tcs, losc, ovf, o_rst, o_clk, o_rdl;
   logic rd_d, pc_irq, xirq, tirq, tclk, ext_rst, p;
   logic [3:0] addr, pl;
   logic [7:0] wdata, rdata, girq, pwr, d;
   logic [1:0] mode;
   logic [5:0] pad, pins_o, oe, ph, ext_d, ext_en;
   logic [15:0] q[$];  // Expected read data and mask
   int errors, comparisons;
   io_port i_io_port (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .CTRL_PAGE_I(page),
      .WR_I(wr), .RD_I(rd), .WDATA_I(wdata), .RDATA_O(rdata), .ENI_I(enable_irq_instr), .DISABLE_IRQ_INSTR_I(disable_irq_instr),
      .EDGE_SEL_I(edge_sel), .TIMER_CS_I(tcs), .LOW_OSC_TM_I(losc), .TIMER_OVF_I(ovf),
      .OPT_EXT_RST_I(o_rst), .OPT_CLK_OUT_I(o_clk), .OPT_RD_LATCH_I(o_rdl),
      .OP_MODE_I(mode), .PINS_I(pad), .PINS_O(pins_o), .PINS_OE_O(oe), .PULL_HIGH_O(ph),
      .PULL_LOW_O(pl), .PC_IRQ_O(pc_irq), .XIRQ_O(xirq), .TIMER_IRQ_O(tirq),
      .TIMER_CLK_O(tclk), .EXT_RST_O(ext_rst), .GIRQ_TIMER_O(girq), .POWER_CTRL_O(pwr));
   pad_model i_pad_model (.clk_i(clk), .out_i(pins_o), .oe_i(oe), .ph_i(ph), .pl_i(pl),
      .ext_d_i(ext_d), .ext_en_i(ext_en), .pad_o(pad));
   // Free-running 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic pg, input logic [3:0] a, input logic [7:0] v);
      page = pg; addr = a; wdata = v; wr = 1'b1;
      tick(1);
      wr = 1'b0;
      tick(1);
   endtask
   task automatic rd_reg(input logic pg, input logic [3:0] a, input logic [7:0] e, m);
      q.push_back({e, m});
      page = pg; addr = a; rd = 1'b1;
      tick(1);
      rd = 1'b0;
      tick(1);
   endtask
   task automatic pulse_eni();
      enable_irq_instr = 1'b1;
      tick(1);
      enable_irq_instr = 1'b0;
   endtask
   // Read data watcher: oldest note against the returned byte
   always @(posedge clk) rd_d <= rd;
   always @(negedge clk) begin
      if (rd_d) begin
         if (q.size() == 0) chk(8'hxx, 8'h00);
         else chk(rdata & q[0][7:0], q[0][15:8]);
         if (q.size() != 0) void'(q.pop_front());
      end
   end
   task automatic tally_and_finish();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Main sequence
   initial begin
      {page, wr, rd, enable_irq_instr, disable_irq_instr, edge_sel, tcs, losc, ovf, o_rst, o_clk, o_rdl} = '0;
      rst = 1'b1; addr = 4'h0; wdata = 8'h00; mode = 2'b00; ext_d = 6'h3f; ext_en = 6'h00;
      errors = 0; comparisons = 0;
      void'($urandom(32'hdaa5));
      tick(10);
      rst = 1'b0;
      tick(1);
      rd_reg(1, ADDR_DIRECTION, {2'b00, RST_DIR}, 8'h3f);
      rd_reg(1, ADDR_OPEN_DRAIN, 8'h00, 8'h37);
      rd_reg(1, ADDR_GIRQ_TIMER, 8'h01, 8'h81);
      rd_reg(0, ADDR_PULL_LOW, 8'hff, 8'hff);
      rd_reg(0, ADDR_PULL_HIGH, 8'h3f, 8'h3f);
      rd_reg(0, ADDR_IRQ_FLAG, 8'h00, 8'h07);
      rd_reg(0, 4'h0, 8'h00, 8'hff);
      d = 8'($urandom);
      wr_reg(0, ADDR_PC_SELECT, d);
      rd_reg(0, ADDR_PC_SELECT, d & 8'h3f, 8'h3f);
      wr_reg(0, ADDR_PC_SELECT, 8'h3f);
      // Outputs: push-pull, then open-drain
      o_rdl = 1'b1;
      wr_reg(0, ADDR_PORT_DATA, d);
      wr_reg(1, ADDR_DIRECTION, 8'h00);
      wr_reg(0, ADDR_PULL_HIGH, 8'h00);
      chk({2'b00, oe}, d[3] ? 8'h37 : 8'h3f);
      chk({2'b00, pins_o}, d & 8'h3f);
      chk({2'b00, ph}, 8'h00);
      rd_reg(0, ADDR_PORT_DATA, d & 8'h3f, 8'h3f);
      wr_reg(1, ADDR_OPEN_DRAIN, 8'h3f);
      chk({2'b00, oe}, ~d & 8'h3f);
      wr_reg(1, ADDR_DIRECTION, 8'h3f);
      wr_reg(0, ADDR_PULL_LOW, 8'h00);
      ext_en = 6'h3f;
      chk({2'b00, ph}, 8'h3f);
      chk({4'h0, pl}, 8'h0f);
      chk({2'b00, oe}, 8'h00);
      // Pin change on every pin, then clear the flag
      wr_reg(0, ADDR_IRQ_ENABLE, 8'h07);
      wr_reg(0, ADDR_IRQ_FLAG, 8'h00);
      pulse_eni();
      tcs = 1'b1;
      for (int i = 0; i < 6; i++) begin
         ext_d[i] = ~ext_d[i];
         tick(5);
         chk({7'h00, pc_irq}, 8'h01);
         chk({7'h00, tclk}, {7'h00, ext_d[2]});
         rd_reg(0, ADDR_IRQ_FLAG, 8'h02, 8'h02);
         wr_reg(0, ADDR_IRQ_FLAG, 8'h00);
         tick(1);
         chk({7'h00, pc_irq}, 8'h00);
      end
      chk({7'h00, tclk}, {7'h00, ext_d[2]});
      // Pin 0 as external irq, excluded from pin change
      wr_reg(0, ADDR_POWER_CTRL, 8'h48);
      edge_sel = 1'b1;
      ext_d[0] = 1'b1;
      tick(5);
      chk({7'h00, pc_irq}, 8'h00);
      chk({7'h00, xirq}, 8'h01);
      // Falling-edge selection on pin 0
      wr_reg(0, ADDR_IRQ_FLAG, 8'h00);
      edge_sel = 1'b0;
      tick(1);
      chk({7'h00, xirq}, 8'h00);
      ext_d[0] = 1'b0;
      tick(5);
      chk({7'h00, xirq}, 8'h01);
      wr_reg(0, ADDR_IRQ_ENABLE, 8'h03);
      rd_reg(0, ADDR_IRQ_FLAG, 8'h00, 8'h04);
      wr_reg(0, ADDR_IRQ_ENABLE, 8'h07);
      disable_irq_instr = 1'b1;
      tick(1);
      disable_irq_instr = 1'b0;
      tick(2);
      chk({7'h00, xirq}, 8'h00);
      // Deselected pin raises nothing
      wr_reg(0, ADDR_PC_SELECT, 8'h3d);
      pulse_eni();
      ext_d[1] = ~ext_d[1];
      tick(5);
      chk({7'h00, pc_irq}, 8'h00);
      ovf = 1'b1;
      tick(1);
      ovf = 1'b0;
      tick(2);
      chk({7'h00, tirq}, 8'h01);
      // Pin 3 reset option and clock output on pin 4
      o_rst = 1'b1;
      ext_d[3] = 1'b0;
      tick(5);
      chk({7'h00, ext_rst}, 8'h01);
      o_clk = 1'b1;
      mode = 2'b10;
      tick(4);
      p = pins_o[4];
      tick(1);
      chk({7'h00, pins_o[4]}, {7'h00, ~p});
      // Halt mode stops the clock output
      mode = 2'b01;
      tick(2);
      p = pins_o[4];
      tick(1);
      chk({7'h00, pins_o[4]}, {7'h00, p});
      tally_and_finish();
   end
endmodule
